// File: asf_audio_master.sv
// behavioural audio master driving bit clock, word select and data
`timescale 1ns/1ps
`default_nettype none
module asf_audio_master (
    input wire logic i_sd,
    output logic o_link_clk,
    output logic o_ws,
    output logic o_sd
);
    initial
    begin
        o_link_clk = 1'h0;
        o_ws = 1'h0;
        o_sd = 1'h0;
    end

    // one bit slot; the clock stands low outside slots
    task automatic bit_slot(input logic ws, input logic sd, output logic got);
        o_ws = ws;
        o_sd = sd;
        #16;
        o_link_clk = 1'h1;
        #16;
        o_link_clk = 1'h0;
        got = i_sd;
    endtask : bit_slot

    // bit clocks with word select held, data toggling
    task automatic idle(input int n, input logic ws);
        logic g;
        for (int i = 0; i < n; i++)
            bit_slot(ws, ~o_sd, g);
    endtask : idle

    // one 16-bit word msb first, then one held slot; slave bits lag one slot
    task automatic word(input logic ws, input logic [15:0] data, input int flip_at,
                        output logic [15:0] got);
        logic g;
        for (int i = 0; i < 16; i++)
        begin
            bit_slot((i >= flip_at) ? ~ws : ws, data[15 - i], g);
            if (i > 0)
                got[16 - i] = g;
        end
        bit_slot((flip_at < 16) ? ~ws : ws, ~data[0], g);
        got[0] = g;
    endtask : word
endmodule : asf_audio_master
`default_nettype wire

// File: asf_audio_serial_slave_flags.sv
// slave-side audio serial port with buffer, error and busy flags
`timescale 1ns/1ps
`default_nettype none
module asf_audio_serial_slave_flags (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_link_clk,
    input wire logic i_ws,
    input wire logic i_sd,
    output logic o_sd,
    output logic o_sd_oe_n,
    input wire asf_pkg::asf_ctrl_s i_ctrl,
    input wire logic i_dr_wr,
    input wire logic [15:0] i_dr_wdata,
    input wire logic i_dr_rd,
    input wire logic i_sr_rd,
    output logic [15:0] o_dr_rdata,
    output asf_pkg::asf_status_s o_status,
    output logic o_irq,
    output logic o_tx_dma_req,
    output logic o_rx_dma_req
);
    // system side state
    logic pend_q;
    logic [15:0] tx_buf_q;
    logic txe_q;
    logic rx_buffer_full_flag_q;
    logic ovr_q;
    logic ovr_rd_q;
    logic udr_q;
    logic fre_q;
    logic channel_side_flag_q;
    logic busy_q;
    logic [15:0] rdata_q;
    logic irq_q;
    logic txdma_q;
    logic rxdma_q;
    asf_pkg::asf_link_cfg_s cfg_q;
    logic [asf_pkg::EV_N-1:0] ev_s1_q;
    logic [asf_pkg::EV_N-1:0] ev_s2_q;
    logic [asf_pkg::EV_N-1:0] ev_s3_q;
    logic bsy_s1_q;
    logic bsy_s2_q;
    // link side state
    asf_pkg::asf_link_cfg_s cfg_l1_q;
    asf_pkg::asf_link_cfg_s cfg_l2_q;
    logic pend_l1_q;
    logic pend_l2_q;
    logic ws_q;
    logic ws_p_q;
    logic chg_d_q;
    logic sd_in_q;
    logic act_q;
    logic [3:0] cnt_q;
    logic bsy_l_q;
    logic side_q;
    logic ld_side_q;
    logic [15:0] tsh_q;
    logic [15:0] rsh_q;
    logic [15:0] rx_hold_q;
    logic rx_side_q;
    logic sd_q;
    logic oe_n_q;
    logic [asf_pkg::EV_N-1:0] ev_tgl_q;

    logic en;
    logic tx_role;
    logic slave_role;
    logic [asf_pkg::EV_N-1:0] ev;
    logic accept_wr;
    logic rx_accept;
    logic rx_drop;
    logic chg;
    logic start;

    assign en = i_ctrl.port_enable & i_ctrl.audio_mode_select;
    assign tx_role = ~i_ctrl.audio_role_direction[0];
    assign slave_role = ~i_ctrl.audio_role_direction[1];
    assign ev = ev_s2_q ^ ev_s3_q;
    assign accept_wr = i_dr_wr & en & tx_role & ~pend_q;
    assign rx_accept = ev[asf_pkg::EV_RX] & en & ~tx_role & ~rx_buffer_full_flag_q & ~ovr_q;
    assign rx_drop = ev[asf_pkg::EV_RX] & en & ~tx_role & (rx_buffer_full_flag_q | ovr_q);

    // configuration handed to the link side
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            cfg_q <= '0;
        end
        else
        begin
            cfg_q.en <= en;
            cfg_q.tx <= tx_role;
            cfg_q.delayed <= (i_ctrl.standard == asf_pkg::STD_DELAYED);
        end
    end

    // event toggles and busy level into the system clock
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            ev_s1_q <= '0;
            ev_s2_q <= '0;
            ev_s3_q <= '0;
            bsy_s1_q <= 1'b0;
            bsy_s2_q <= 1'b0;
        end
        else
        begin
            ev_s1_q <= ev_tgl_q;
            ev_s2_q <= ev_s1_q;
            ev_s3_q <= ev_s2_q;
            bsy_s1_q <= bsy_l_q;
            bsy_s2_q <= bsy_s1_q;
        end
    end

    // transmit buffer
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            pend_q <= 1'b0;
            tx_buf_q <= '0;
            txe_q <= 1'b0;
        end
        else
        begin
            if (accept_wr)
            begin
                tx_buf_q <= i_dr_wdata;
            end
            if (!en)
            begin
                pend_q <= 1'b0;
            end
            else if (accept_wr)
            begin
                pend_q <= 1'b1;
            end
            else if (ev[asf_pkg::EV_LOAD])
            begin
                pend_q <= 1'b0;
            end
            txe_q <= en & tx_role & ~(accept_wr | (pend_q & ~ev[asf_pkg::EV_LOAD]));
        end
    end

    // receive buffer and overrun
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            rx_buffer_full_flag_q <= 1'b0;
            rdata_q <= '0;
            ovr_q <= 1'b0;
            ovr_rd_q <= 1'b0;
        end
        else
        begin
            if (rx_accept)
            begin
                rdata_q <= rx_hold_q;
                rx_buffer_full_flag_q <= 1'b1;
            end
            else if (i_dr_rd)
            begin
                rx_buffer_full_flag_q <= 1'b0;
            end
            if (rx_drop)
            begin
                ovr_q <= 1'b1;
                ovr_rd_q <= 1'b0;
            end
            else if (ovr_q && i_sr_rd && ovr_rd_q)
            begin
                ovr_q <= 1'b0;
                ovr_rd_q <= 1'b0;
            end
            else if (ovr_q && i_dr_rd)
            begin
                ovr_rd_q <= 1'b1;
            end
        end
    end

    // error flags, channel side, busy
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            udr_q <= 1'b0;
            fre_q <= 1'b0;
            channel_side_flag_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            if (ev[asf_pkg::EV_UNDER] && en
                && i_ctrl.audio_role_direction == asf_pkg::ROLE_SLAVE_TX)
            begin
                udr_q <= 1'b1;
            end
            else if (i_sr_rd)
            begin
                udr_q <= 1'b0;
            end
            if (ev[asf_pkg::EV_FRAME] && en && slave_role)
            begin
                fre_q <= 1'b1;
            end
            else if (i_sr_rd)
            begin
                fre_q <= 1'b0;
            end
            if (ev[asf_pkg::EV_LOAD] && en && tx_role)
            begin
                channel_side_flag_q <= ld_side_q;
            end
            else if (rx_accept)
            begin
                channel_side_flag_q <= rx_side_q;
            end
            busy_q <= en & bsy_s2_q
                & (i_ctrl.audio_role_direction != asf_pkg::ROLE_MASTER_RX);
        end
    end

    // interrupt and dma requests
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            irq_q <= 1'b0;
            txdma_q <= 1'b0;
            rxdma_q <= 1'b0;
        end
        else
        begin
            irq_q <= (txe_q & i_ctrl.tx_empty_irq_enable)
                | (rx_buffer_full_flag_q & i_ctrl.rx_full_irq_enable)
                | ((ovr_q | udr_q | fre_q) & i_ctrl.error_irq_enable);
            txdma_q <= txe_q & i_ctrl.tx_dma_enable;
            rxdma_q <= rx_buffer_full_flag_q & i_ctrl.rx_dma_enable;
        end
    end

    // link side: synchronisers and framing
    assign chg = ws_q ^ ws_p_q;
    assign start = cfg_l2_q.en & (cfg_l2_q.delayed ? chg_d_q : chg);

    always_ff @(posedge i_link_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            cfg_l1_q <= '0;
            cfg_l2_q <= '0;
            pend_l1_q <= 1'b0;
            pend_l2_q <= 1'b0;
            ws_q <= 1'b0;
            ws_p_q <= 1'b0;
            chg_d_q <= 1'b0;
            sd_in_q <= 1'b0;
        end
        else
        begin
            cfg_l1_q <= cfg_q;
            cfg_l2_q <= cfg_l1_q;
            pend_l1_q <= pend_q;
            pend_l2_q <= pend_l1_q;
            ws_q <= i_ws;
            ws_p_q <= ws_q;
            chg_d_q <= chg;
            sd_in_q <= i_sd;
        end
    end

    // link side: bit counter, busy, frame check
    always_ff @(posedge i_link_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            act_q <= 1'b0;
            cnt_q <= asf_pkg::BIT_ZERO;
            bsy_l_q <= 1'b0;
            side_q <= 1'b0;
            ev_tgl_q <= '0;
        end
        else if (!cfg_l2_q.en)
        begin
            act_q <= 1'b0;
            cnt_q <= asf_pkg::BIT_ZERO;
            bsy_l_q <= 1'b0;
        end
        else
        begin
            if (start)
            begin
                act_q <= 1'b1;
                cnt_q <= asf_pkg::BIT_ZERO;
                side_q <= ws_q;
            end
            else if (act_q && cnt_q != asf_pkg::BIT_LAST)
            begin
                cnt_q <= cnt_q + asf_pkg::BIT_ONE;
            end
            else
            begin
                act_q <= 1'b0;
            end
            bsy_l_q <= start | (act_q & (cnt_q < asf_pkg::FRE_GUARD));
            if (chg && act_q && cnt_q < asf_pkg::FRE_GUARD)
            begin
                ev_tgl_q[asf_pkg::EV_FRAME] <= ~ev_tgl_q[asf_pkg::EV_FRAME];
            end
            if (start && cfg_l2_q.tx)
            begin
                if (pend_l2_q)
                begin
                    ev_tgl_q[asf_pkg::EV_LOAD] <= ~ev_tgl_q[asf_pkg::EV_LOAD];
                end
                else
                begin
                    ev_tgl_q[asf_pkg::EV_UNDER] <= ~ev_tgl_q[asf_pkg::EV_UNDER];
                end
            end
            if (act_q && !cfg_l2_q.tx && cnt_q == asf_pkg::FRE_GUARD)
            begin
                ev_tgl_q[asf_pkg::EV_RX] <= ~ev_tgl_q[asf_pkg::EV_RX];
            end
        end
    end

    // link side: shifters and data pin
    always_ff @(posedge i_link_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            tsh_q <= '0;
            rsh_q <= '0;
            rx_hold_q <= '0;
            rx_side_q <= 1'b0;
            ld_side_q <= 1'b0;
            sd_q <= 1'b0;
            oe_n_q <= 1'b1;
        end
        else
        begin
            oe_n_q <= ~(cfg_l2_q.en & cfg_l2_q.tx);
            if (start)
            begin
                tsh_q <= pend_l2_q ? {tx_buf_q[14:0], 1'b0} : '0;
                sd_q <= pend_l2_q & tx_buf_q[asf_pkg::WORD_W-1];
                ld_side_q <= ws_q;
                rsh_q <= {15'h0000, sd_in_q};
            end
            else if (act_q)
            begin
                tsh_q <= {tsh_q[14:0], 1'b0};
                sd_q <= tsh_q[asf_pkg::WORD_W-1];
                rsh_q <= {rsh_q[14:0], sd_in_q};
            end
            else
            begin
                sd_q <= 1'b0;
            end
            if (act_q && cnt_q == asf_pkg::FRE_GUARD)
            begin
                rx_hold_q <= {rsh_q[14:0], sd_in_q};
                rx_side_q <= side_q;
            end
        end
    end

    assign o_sd = sd_q;
    assign o_sd_oe_n = oe_n_q;
    assign o_dr_rdata = rdata_q;
    assign o_status = '{frame_error_flag: fre_q, busy_flag: busy_q, overrun_flag: ovr_q,
        underrun_flag: udr_q, channel_side_flag: channel_side_flag_q, tx_buffer_empty_flag: txe_q,
        rx_buffer_full_flag: rx_buffer_full_flag_q};
    assign o_irq = irq_q;
    assign o_tx_dma_req = txdma_q;
    assign o_rx_dma_req = rxdma_q;

    // checks
    a_txe_when_disabled:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !en |=> !txe_q) else $error("tx empty set while disabled");
    a_txe_after_load:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (ev[asf_pkg::EV_LOAD] && en && tx_role && !i_dr_wr) |=> txe_q)
        else $error("tx empty not set after load");
    a_udr_set_event:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (ev[asf_pkg::EV_UNDER] && en && i_ctrl.audio_role_direction == asf_pkg::ROLE_SLAVE_TX)
        |=> udr_q ##1 (udr_q || $past(i_sr_rd))) else $error("underrun not raised");
    a_udr_read_clear:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_sr_rd && !ev[asf_pkg::EV_UNDER]) |=> !udr_q) else $error("underrun not cleared");
    a_rx_word_full:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        rx_accept |=> rx_buffer_full_flag_q && rdata_q == $past(rx_hold_q)) else $error("rx word lost");
    a_rx_side_update:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        rx_accept |=> channel_side_flag_q == $past(rx_side_q)) else $error("rx side wrong");
    a_rx_buffer_full_flag_read_clear:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_dr_rd && !rx_accept) |=> !rx_buffer_full_flag_q) else $error("rx full not cleared");
    a_ovr_keeps_data:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        rx_drop |=> ovr_q && $stable(rdata_q)) else $error("overrun corrupted data");
    a_ovr_needs_both:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (ovr_q && !ovr_rd_q && !i_dr_rd) |=> ovr_q) else $error("overrun cleared early");
    a_busy_master_rx:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_ctrl.audio_role_direction == asf_pkg::ROLE_MASTER_RX) |=> !busy_q)
        else $error("busy in master receive");
    a_busy_disabled:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !en |=> !busy_q) else $error("busy while disabled");
    a_busy_gap_link:
    assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
        (act_q && cnt_q == asf_pkg::FRE_GUARD && !start) |=> !bsy_l_q)
        else $error("no busy gap");
    a_tx_msb_first:
    assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
        (start && pend_l2_q) |=> sd_q == $past(tx_buf_q[15]) ##1 sd_q == $past(tx_buf_q[14], 2))
        else $error("tx bit order wrong");
    a_frame_slave_only:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!slave_role && !fre_q) |=> !fre_q) else $error("frame error in master role");
    a_error_irq:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ((ovr_q || udr_q || fre_q) && i_ctrl.error_irq_enable) |=> o_irq)
        else $error("error interrupt missing");
    a_tx_dma_req:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (txe_q && i_ctrl.tx_dma_enable) |=> o_tx_dma_req) else $error("tx dma missing");
    a_rx_dma_req:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rx_buffer_full_flag_q && i_ctrl.rx_dma_enable) |=> o_rx_dma_req) else $error("rx dma missing");
endmodule : asf_audio_serial_slave_flags
`default_nettype wire

// File: asf_pkg.sv
// shared constants and carriers for the audio serial slave flag block
package asf_pkg;
    localparam int WORD_W = 16;
    localparam logic [3:0] BIT_LAST = 4'hF;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam logic [3:0] FRE_GUARD = 4'hE;
    localparam int ENABLE_LEAD_CYCLES = 2;
    localparam logic [1:0] ROLE_SLAVE_TX = 2'h0;
    localparam logic [1:0] ROLE_SLAVE_RX = 2'h1;
    localparam logic [1:0] ROLE_MASTER_TX = 2'h2;
    localparam logic [1:0] ROLE_MASTER_RX = 2'h3;
    localparam logic [1:0] STD_DELAYED = 2'h0;
    localparam int EV_LOAD = 0;
    localparam int EV_UNDER = 1;
    localparam int EV_FRAME = 2;
    localparam int EV_RX = 3;
    localparam int EV_N = 4;

    typedef struct packed {
        logic port_enable;
        logic audio_mode_select;
        logic [1:0] audio_role_direction;
        logic [1:0] standard;
        logic tx_empty_irq_enable;
        logic rx_full_irq_enable;
        logic error_irq_enable;
        logic tx_dma_enable;
        logic rx_dma_enable;
    } asf_ctrl_s;

    typedef struct packed {
        logic frame_error_flag;
        logic busy_flag;
        logic overrun_flag;
        logic underrun_flag;
        logic channel_side_flag;
        logic tx_buffer_empty_flag;
        logic rx_buffer_full_flag;
    } asf_status_s;

    typedef struct packed {
        logic en;
        logic tx;
        logic delayed;
    } asf_link_cfg_s;
endpackage : asf_pkg

// File: tb.sv
// self-checking bench for the audio serial slave flag block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic link_clk, ws, sd_in, sd_out, oe_n, irq, tx_dma, rx_dma;
    logic [2:0] req = 3'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic [15:0] seen;
    asf_pkg::asf_ctrl_s ctrl = 11'h000;
    asf_pkg::asf_status_s st;
    int n_errors = 0;
    int check_count = 0;
    // rows: word select level, received word; expect same data and side
    logic [16:0] rows [4] = '{17'h1A5C3, 17'h00001, 17'h18000, 17'h0FFFF};

    always #5 clk = ~clk;

    asf_audio_serial_slave_flags asf_audio_serial_slave_flags_i (
        .i_clk(clk), .i_sys_rst(rst), .i_link_clk(link_clk), .i_ws(ws), .i_sd(sd_in),
        .o_sd(sd_out), .o_sd_oe_n(oe_n), .i_ctrl(ctrl), .i_dr_wr(req[2]),
        .i_dr_wdata(wdata), .i_dr_rd(req[1]), .i_sr_rd(req[0]), .o_dr_rdata(rdata),
        .o_status(st), .o_irq(irq), .o_tx_dma_req(tx_dma), .o_rx_dma_req(rx_dma));

    asf_audio_master asf_audio_master_i (
        .i_sd(sd_out), .o_link_clk(link_clk), .o_ws(ws), .o_sd(sd_in));

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk1(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk1

    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk16

    // bounded wait for one status bit
    task automatic wait_bit(input int idx, input logic val);
        logic [6:0] s;
        for (int i = 0; i < 60; i++)
        begin
            @(posedge clk);
            #1;
            s = st;
            if (s[idx] === val)
                return;
        end
        n_errors++;
        $display("wrong value status bit %0d expected %h seen %h", idx, val, s[idx]);
        end_of_test();
    endtask : wait_bit

    // one-cycle pulse: write, data read, status read
    task automatic pulse(input logic [2:0] p);
        @(posedge clk);
        req <= p;
        @(posedge clk);
        req <= 3'h0;
        #1;
    endtask : pulse

    task automatic set_ctrl(input logic en, input logic [1:0] role, input logic [4:0] ie);
        @(posedge clk);
        ctrl <= asf_pkg::asf_ctrl_s'({en, 1'h1, role, 2'h1, ie});
    endtask : set_ctrl

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    initial
    begin
        asf_audio_master_i.idle(2, 1'h0);
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        settle();
        chk16("status after reset", 16'h0000, {9'h000, st});
        chk1("oe_n after reset", 1'h1, oe_n);
        chk1("irq after reset", 1'h0, irq);
        $display("test reset done");

        set_ctrl(1'h1, asf_pkg::ROLE_SLAVE_RX, 5'h1F);
        repeat (3) @(posedge clk);
        asf_audio_master_i.idle(4, 1'h0);
        foreach (rows[k])
        begin
            asf_audio_master_i.word(rows[k][16], rows[k][15:0], 16, seen);
            wait_bit(0, 1'h1);
            settle();
            chk16("rx data", rows[k][15:0], rdata);
            chk1("rx side", rows[k][16], st.channel_side_flag);
            chk1("rx dma", 1'h1, rx_dma);
            chk1("irq rx", 1'h1, irq);
            pulse(3'h2);
            chk1("rx full", 1'h0, st.rx_buffer_full_flag);
        end
        $display("test rx rows done");

        set_ctrl(1'h1, asf_pkg::ROLE_SLAVE_RX, 5'h04);
        asf_audio_master_i.word(1'h1, 16'h1234, 16, seen);
        asf_audio_master_i.word(1'h0, 16'h5678, 16, seen);
        wait_bit(4, 1'h1);
        chk16("kept data", 16'h1234, rdata);
        settle();
        chk1("irq overrun", 1'h1, irq);
        pulse(3'h1);
        chk1("overrun after status", 1'h1, st.overrun_flag);
        pulse(3'h2);
        pulse(3'h1);
        chk1("overrun cleared", 1'h0, st.overrun_flag);
        set_ctrl(1'h0, asf_pkg::ROLE_SLAVE_RX, 5'h04);
        $display("test overrun done");

        settle();
        set_ctrl(1'h1, asf_pkg::ROLE_SLAVE_RX, 5'h04);
        asf_audio_master_i.idle(4, 1'h0);
        asf_audio_master_i.word(1'h1, 16'hC0DE, 5, seen);
        wait_bit(6, 1'h1);
        settle();
        chk1("irq frame", 1'h1, irq);
        pulse(3'h1);
        chk1("frame error cleared", 1'h0, st.frame_error_flag);
        set_ctrl(1'h0, asf_pkg::ROLE_SLAVE_RX, 5'h04);
        asf_audio_master_i.idle(3, 1'h0);
        $display("test frame error done");

        set_ctrl(1'h1, asf_pkg::ROLE_MASTER_RX, 5'h00);
        asf_audio_master_i.idle(4, 1'h0);
        fork
            asf_audio_master_i.word(1'h1, 16'h0F0F, 16, seen);
            begin
                #(32 * 10);
                chk1("busy master rx", 1'h0, st.busy_flag);
            end
        join
        wait_bit(0, 1'h1);
        chk16("rx master", 16'h0F0F, rdata);
        pulse(3'h2);
        set_ctrl(1'h0, asf_pkg::ROLE_MASTER_RX, 5'h00);
        asf_audio_master_i.idle(3, 1'h0);
        $display("test master rx done");

        set_ctrl(1'h1, asf_pkg::ROLE_SLAVE_TX, 5'h1F);
        wait_bit(1, 1'h1);
        @(posedge clk);
        wdata <= 16'hA55A;
        pulse(3'h4);
        chk1("txe pending", 1'h0, st.tx_buffer_empty_flag);
        asf_audio_master_i.idle(4, 1'h0);
        fork
            asf_audio_master_i.word(1'h1, 16'h0000, 16, seen);
            begin
                #(32 * 8);
                chk1("busy tx", 1'h1, st.busy_flag);
                chk1("oe_n tx", 1'h0, oe_n);
            end
        join
        chk16("tx bits", 16'hA55A, seen);
        wait_bit(1, 1'h1);
        settle();
        chk1("tx side", 1'h1, st.channel_side_flag);
        chk1("tx dma", 1'h1, tx_dma);
        chk1("irq tx", 1'h1, irq);
        asf_audio_master_i.word(1'h0, 16'h0000, 16, seen);
        wait_bit(3, 1'h1);
        pulse(3'h1);
        chk1("underrun cleared", 1'h0, st.underrun_flag);
        wait_bit(5, 1'h0);
        chk1("txe before stop", 1'h1, st.tx_buffer_empty_flag);
        set_ctrl(1'h0, asf_pkg::ROLE_SLAVE_TX, 5'h1F);
        repeat (3) @(posedge clk);
        #1;
        chk1("txe disabled", 1'h0, st.tx_buffer_empty_flag);
        chk1("busy disabled", 1'h0, st.busy_flag);
        $display("test tx done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
